// ==== sgp_pkg.sv ====
package sgp_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_LINES = 9;
    localparam int unsigned LOW_LINES = 8;
    localparam int unsigned LINE8     = 8;
    localparam int unsigned ADDR_W    = 16;
    localparam int unsigned DATA_W    = 32;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [13:0] IDX_DIR_LOW     = 14'h2004;
    localparam logic [13:0] IDX_DATA_LOW    = 14'h2005;
    localparam logic [13:0] IDX_IEN_LOW     = 14'h2006;
    localparam logic [13:0] IDX_FLAG_LOW    = 14'h2007;
    localparam logic [13:0] IDX_DIR_LINE8   = 14'h2044;
    localparam logic [13:0] IDX_DATA_LINE8  = 14'h2045;
    localparam logic [13:0] IDX_IEN_LINE8   = 14'h2046;
    localparam logic [13:0] IDX_FLAG_LINE8  = 14'h2047;
    localparam logic [13:0] IDX_FUNC_SEL    = 14'h2049;
    localparam logic [13:0] IDX_IRQ_STATUS  = 14'h2050;
    localparam logic [13:0] IDX_IRQ_MASK    = 14'h2051;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned L8_DATA_BIT  = 0;
    localparam int unsigned L8_MODE_BIT  = 1;
    localparam int unsigned ST_LOW_BIT   = 0;
    localparam int unsigned ST_LINE8_BIT = 1;
    localparam int unsigned ST_W         = 2;
    localparam logic [7:0]  SEL_RST      = 8'hff;
    localparam logic [7:0]  LOW_ZERO     = 8'h00;
    localparam logic        MODE_RST     = 1'b1;
    localparam logic [1:0]  ST_ZERO      = 2'h0;
    localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

    // ------------------------------------------------------------
    // Pin drive bundle
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0] out;
        logic [8:0] oe;
    } sgp_pin_drive_t;

endpackage : sgp_pkg

// ==== sgp_port.sv ====
`timescale 1ns/100ps

module sgp_port
    import sgp_pkg::*;
(
    // Clock and reset.
    input  wire logic                 mclk_in,
    input  wire logic                 reset_in,
    // APB slave.
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [ADDR_W-1:0]    paddr_in,
    input  wire logic [DATA_W-1:0]    pwdata_in,
    input  wire logic [3:0]           pstrb_in,
    output logic      [DATA_W-1:0]    prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    // Shared pins.
    input  wire logic [NUM_LINES-1:0] pin_in,
    output sgp_pin_drive_t            pin_out,
    // Alternate functions (serial port, clock output, aux pwm).
    input  wire logic [NUM_LINES-1:0] alt_drive_in,
    input  wire logic [NUM_LINES-1:0] alt_oe_in,
    output logic      [NUM_LINES-1:0] alt_level_out,
    // Interrupts.
    output logic                      peripheral_irq_line_n_out,
    output logic                      irq_out
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]           func_sel_ff;
    logic [7:0]           dir_low_ff;
    logic                 dir_l8_ff;
    logic [7:0]           data_low_ff;
    logic                 data_l8_ff;
    logic                 mode_l8_ff;
    logic [7:0]           ien_low_ff;
    logic                 ien_l8_ff;
    logic [7:0]           flag_low_ff;
    logic                 flag_l8_ff;
    logic [ST_W-1:0]      irq_status_ff;
    logic [ST_W-1:0]      irq_mask_ff;
    logic [NUM_LINES-1:0] sync1_ff;
    logic [NUM_LINES-1:0] sync2_ff;
    logic [NUM_LINES-1:0] prev_ff;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [13:0]          idx;
    logic                 acc_first;
    logic                 commit;
    logic                 wr_en;
    logic                 rd_en;
    logic                 mapped;
    logic [DATA_W-1:0]    rd_value;

    // A transfer commits only at the edge where pready is seen high.
    assign idx       = paddr_in[ADDR_W-1:2];
    assign acc_first = psel_in && penable_in && !pready_out;
    assign commit    = psel_in && penable_in && pready_out;
    assign wr_en     = commit && pwrite_in && pstrb_in[0] && !pslverr_out;
    assign rd_en     = commit && !pwrite_in;

    // ------------------------------------------------------------
    // Line roles
    // ------------------------------------------------------------
    logic [NUM_LINES-1:0] gio;
    logic [NUM_LINES-1:0] dir_all;
    logic [NUM_LINES-1:0] data_all;
    logic [NUM_LINES-1:0] src_en;
    logic [NUM_LINES-1:0] change;
    logic [NUM_LINES-1:0] level_view;

    // Lines 0..5 serial, 6 clock output, 7 aux one, 8 aux zero.
    assign gio      = {mode_l8_ff, func_sel_ff};
    assign dir_all  = {dir_l8_ff, dir_low_ff};
    assign data_all = {data_l8_ff, data_low_ff};
    // A line in output or alternate mode can never flag a change.
    assign src_en   = gio & ~dir_all & {ien_l8_ff, ien_low_ff};
    assign change   = sync2_ff ^ prev_ff;
    // Inputs read the pin, outputs read back their own latch.
    assign level_view = (sync2_ff & ~dir_all) | (data_all & dir_all);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        mapped   = 1'b1;
        rd_value = RD_ZERO;
        case (idx)
            IDX_DIR_LOW:    rd_value[7:0] = dir_low_ff;
            IDX_DATA_LOW:   rd_value[7:0] = level_view[7:0];
            IDX_IEN_LOW:    rd_value[7:0] = ien_low_ff;
            IDX_FLAG_LOW:   rd_value[7:0] = flag_low_ff;
            IDX_DIR_LINE8:  rd_value[0]   = dir_l8_ff;
            IDX_DATA_LINE8: rd_value[1:0] = {mode_l8_ff, level_view[LINE8]};
            IDX_IEN_LINE8:  rd_value[0]   = ien_l8_ff;
            IDX_FLAG_LINE8: rd_value[0]   = flag_l8_ff;
            IDX_FUNC_SEL:   rd_value[7:0] = func_sel_ff;
            IDX_IRQ_STATUS: rd_value[ST_W-1:0] = irq_status_ff;
            IDX_IRQ_MASK:   rd_value[ST_W-1:0] = irq_mask_ff;
            default:        mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // One wait state: data is captured before the commit edge so the
    // flag clear can be limited to exactly the bits software saw.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= RD_ZERO;
        end else if (acc_first) begin
            pready_out  <= 1'b1;
            pslverr_out <= !mapped;
            prdata_out  <= rd_value;
        end else begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            func_sel_ff <= SEL_RST;
            dir_low_ff  <= LOW_ZERO;
            dir_l8_ff   <= 1'b0;
            ien_low_ff  <= LOW_ZERO;
            ien_l8_ff   <= 1'b0;
            mode_l8_ff  <= MODE_RST;
            irq_mask_ff <= ST_ZERO;
        end else if (wr_en) begin
            case (idx)
                IDX_FUNC_SEL:   func_sel_ff <= pwdata_in[7:0];
                IDX_DIR_LOW:    dir_low_ff  <= pwdata_in[7:0];
                IDX_DIR_LINE8:  dir_l8_ff   <= pwdata_in[0];
                IDX_IEN_LOW:    ien_low_ff  <= pwdata_in[7:0];
                IDX_IEN_LINE8:  ien_l8_ff   <= pwdata_in[0];
                IDX_DATA_LINE8: mode_l8_ff  <= pwdata_in[L8_MODE_BIT];
                IDX_IRQ_MASK:   irq_mask_ff <= pwdata_in[ST_W-1:0];
                default:        ;
            endcase
        end
    end

    // Output data latches; a write to an input line is kept for later.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            data_low_ff <= LOW_ZERO;
            data_l8_ff  <= 1'b0;
        end else if (wr_en && idx == IDX_DATA_LOW) begin
            data_low_ff <= pwdata_in[7:0];
        end else if (wr_en && idx == IDX_DATA_LINE8) begin
            data_l8_ff  <= pwdata_in[L8_DATA_BIT];
        end
    end

    // ------------------------------------------------------------
    // Pin synchroniser and previous sample
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // ------------------------------------------------------------
    // Change flags
    // ------------------------------------------------------------
    logic [NUM_LINES-1:0] set_flag;
    logic [7:0]           clr_low;
    logic                 clr_l8;

    assign set_flag = change & src_en;
    // Only the bits returned by the read are cleared, so a change that
    // lands during the read survives it.
    assign clr_low  = (rd_en && idx == IDX_FLAG_LOW) ? prdata_out[7:0] : LOW_ZERO;
    assign clr_l8   = rd_en && idx == IDX_FLAG_LINE8 && prdata_out[0];

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            flag_low_ff <= LOW_ZERO;
            flag_l8_ff  <= 1'b0;
        end else begin
            flag_low_ff <= (flag_low_ff & ~clr_low) | set_flag[7:0];
            flag_l8_ff  <= (flag_l8_ff & ~clr_l8) | set_flag[LINE8];
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and outputs
    // ------------------------------------------------------------
    logic [ST_W-1:0] st_set;
    logic [ST_W-1:0] st_clr;

    assign st_set = {set_flag[LINE8], |set_flag[7:0]};
    assign st_clr = (wr_en && idx == IDX_IRQ_STATUS) ? pwdata_in[ST_W-1:0] : ST_ZERO;

    // Sticky status: a new event beats a write-one-to-clear.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_status_ff <= ST_ZERO;
        end else begin
            irq_status_ff <= (irq_status_ff & ~st_clr) | st_set;
        end
    end

    // The low-active request stays asserted while any flag is pending,
    // which suits a level-sensitive core input.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            peripheral_irq_line_n_out <= 1'b1;
            irq_out                   <= 1'b0;
        end else begin
            peripheral_irq_line_n_out <= !(|flag_low_ff || flag_l8_ff);
            irq_out                   <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------
    // Pin drive and alternate inputs
    // ------------------------------------------------------------
    // Registered drive costs a cycle of latency on alternate outputs
    // but keeps the pads glitch free.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_out       <= '0;
            alt_level_out <= '0;
        end else begin
            pin_out.out   <= (gio & data_all) | (~gio & alt_drive_in);
            pin_out.oe    <= (gio & dir_all) | (~gio & alt_oe_in);
            alt_level_out <= sync2_ff;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    flag_set_edge_a: assert property (set_flag[0] |=> flag_low_ff[0])
        else $error("enabled change did not set flag");
    src_gate_a: assert property ($rose(flag_l8_ff) |-> $past(src_en[LINE8])
        && $past(change[LINE8]))
        else $error("line8 flag set without enabled source");
    read_clear_a: assert property ((rd_en && idx == IDX_FLAG_LOW && !(|set_flag[7:0]))
        |=> (flag_low_ff & $past(prdata_out[7:0])) == LOW_ZERO)
        else $error("flag read did not clear");
    irq_hold_a: assert property ((|flag_low_ff || flag_l8_ff) |=> !peripheral_irq_line_n_out)
        else $error("request released with flag pending");
    irq_idle_a: assert property (!(|flag_low_ff || flag_l8_ff) |=> peripheral_irq_line_n_out)
        else $error("request asserted with no flag");
    sel_write_a: assert property ((wr_en && idx == IDX_FUNC_SEL)
        |=> func_sel_ff == $past(pwdata_in[7:0]))
        else $error("select write lost");
    gio_drive_a: assert property (gio[3] && dir_all[3] |=> pin_out.oe[3]
        && pin_out.out[3] == $past(data_all[3]))
        else $error("output line not driven from latch");
    line8_alt_a: assert property (!mode_l8_ff |=> pin_out.out[LINE8]
        == $past(alt_drive_in[LINE8]) && pin_out.oe[LINE8] == $past(alt_oe_in[LINE8]))
        else $error("line8 alternate role not routed");
    input_float_a: assert property (gio[0] && !dir_all[0] |=> !pin_out.oe[0])
        else $error("input line driven");
    apb_wait_a: assert property (acc_first |=> pready_out ##1 !pready_out)
        else $error("apb answer timing wrong");

    // ------------------------------------------------------------
    // Bus answer checks
    // ------------------------------------------------------------
    // Ready is a single-cycle pulse, but a master that holds penable
    // after the answer sees ready again two edges later and commits the same transfer twice.
    ready_pulse_a: assert property (pready_out
        |=> !pready_out)
        else $error("ready stood longer than one cycle");
    err_ready_a: assert property (pslverr_out
        |-> pready_out)
        else $error("error seen without ready");
    // A refused or strobe-less write must leave every register alone.
    err_nowrite_a: assert property ((commit && pwrite_in && pslverr_out)
        |=> $stable(func_sel_ff) && $stable(dir_low_ff) && $stable(irq_mask_ff))
        else $error("refused write changed a register");
    strb_guard_a: assert property ((commit && pwrite_in && !pstrb_in[0])
        |=> $stable(func_sel_ff) && $stable(data_low_ff))
        else $error("write without low strobe took effect");

    // ------------------------------------------------------------
    // Line role and pad checks
    // ------------------------------------------------------------
    alt_route_a: assert property (!gio[0]
        |=> pin_out.out[0] == $past(alt_drive_in[0]) && pin_out.oe[0] == $past(alt_oe_in[0]))
        else $error("line0 alternate role not routed");
    sel_route_a: assert property (gio[6] && !dir_all[6]
        |=> !pin_out.oe[6])
        else $error("clock line driven while an input");
    l8_drive_a: assert property (mode_l8_ff && dir_l8_ff
        |=> pin_out.oe[LINE8] && pin_out.out[LINE8] == $past(data_l8_ff))
        else $error("line8 output not driven from latch");
    l8_input_a: assert property (mode_l8_ff && !dir_l8_ff
        |=> !pin_out.oe[LINE8])
        else $error("line8 input driven");
    // Reads are checked against the sources that software should see.
    rd_input_a: assert property ((acc_first && idx == IDX_DATA_LOW && !dir_low_ff[0])
        |=> prdata_out[0] == $past(sync2_ff[0]))
        else $error("input line read wrong level");
    rd_output_a: assert property ((acc_first && idx == IDX_DATA_LOW && dir_low_ff[0])
        |=> prdata_out[0] == $past(data_low_ff[0]))
        else $error("output line read wrong latch");
    rd_mode_a: assert property ((acc_first && idx == IDX_DATA_LINE8)
        |=> prdata_out[L8_MODE_BIT] == $past(mode_l8_ff))
        else $error("line8 mode bit read wrong");

    // ------------------------------------------------------------
    // Change detection and interrupt checks
    // ------------------------------------------------------------
    // Two clean edges are needed before the pipe holds real pin data.
    sync_delay_a: assert property ((!$past(reset_in) && !$past(reset_in, 2))
        |-> sync2_ff == $past(pin_in, 2))
        else $error("pin not seen two edges later");
    no_source_a: assert property ((!gio[2] || dir_all[2])
        |=> !$rose(flag_low_ff[2]))
        else $error("flag set on a line that is no source");
    l8_gate_a: assert property ((!mode_l8_ff || dir_l8_ff)
        |=> !$rose(flag_l8_ff))
        else $error("line8 flag set while no source");
    flag_sticky_a: assert property ((flag_l8_ff && !(rd_en && idx == IDX_FLAG_LINE8))
        |=> flag_l8_ff)
        else $error("line8 flag lost without a read");
    l8_clear_a: assert property ((rd_en && idx == IDX_FLAG_LINE8 && prdata_out[0]
        && !set_flag[LINE8]) |=> !flag_l8_ff)
        else $error("line8 flag read did not clear");
    common_req_a: assert property (|set_flag
        |-> ##2 !peripheral_irq_line_n_out)
        else $error("change did not pull the request low");
    status_set_a: assert property (set_flag[LINE8]
        |=> irq_status_ff[ST_LINE8_BIT])
        else $error("line8 change not in status");

    flag_cov_c:  cover property (set_flag[LINE8] ##1 !peripheral_irq_line_n_out);
    clear_cov_c: cover property (rd_en && idx == IDX_FLAG_LOW && |prdata_out[7:0]);
    irq_cov_c:   cover property ($rose(irq_out));
    alt_cov_c:   cover property (!mode_l8_ff && pin_out.oe[LINE8]);
    strb_cov_c:  cover property (commit && pwrite_in && !pstrb_in[0]);

endmodule : sgp_port

// ==== sgp_pin_model.sv ====
`timescale 1ns/100ps

// ------------------------------------------------------------
// External circuits on the shared pins
// ------------------------------------------------------------
module sgp_pin_model
    import sgp_pkg::*;
(
    // Device pad drive.
    input  wire sgp_pin_drive_t       pad_in,
    // External drivers commanded by the bench.
    input  wire logic [NUM_LINES-1:0] ext_en_in,
    input  wire logic [NUM_LINES-1:0] ext_val_in,
    // Resolved pin levels.
    output logic      [NUM_LINES-1:0] level_out
);
    // The device drive wins; an undriven line sinks to its pull-down level.
    always_comb begin
        for (int i = 0; i < NUM_LINES; i++) begin
            if (pad_in.oe[i]) level_out[i] = pad_in.out[i];
            else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
            else level_out[i] = 1'h0;
        end
    end
endmodule : sgp_pin_model

// ==== testbench.sv ====
`timescale 1ns/100ps

// ------------------------------------------------------------
// Self-checking bench for the shared-pin port
// ------------------------------------------------------------
module testbench;
    import sgp_pkg::*;
    logic                 mclk_in, reset_in, psel, penable, pwrite, pready, pslverr;
    logic                 irq_n, irq;
    logic [ADDR_W-1:0]    paddr;
    logic [DATA_W-1:0]    pwdata, prdata;
    logic [8:0]           pin_lv, alt_drive, alt_oe, alt_lv, ext_en, ext_val;
    logic [8:0]           v, nv, dv;
    logic [7:0]           r;
    logic [33:0]          note;
    logic [33:0]          notes[$];
    logic [31:0]          seed = 32'he82;
    logic [3:0]           pstrb;
    logic [15:0]          core_irq_mask;
    sgp_pin_drive_t       pad;
    int                   bad_count = 0;
    int                   n_tests = 0;

    sgp_port uut (.mclk_in(mclk_in), .reset_in(reset_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .pin_in(pin_lv), .pin_out(pad), .alt_drive_in(alt_drive), .alt_oe_in(alt_oe),
        .alt_level_out(alt_lv), .peripheral_irq_line_n_out(irq_n), .irq_out(irq));
    sgp_pin_model far (.pad_in(pad), .ext_en_in(ext_en), .ext_val_in(ext_val),
        .level_out(pin_lv));

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; the expected answer is noted before the request goes out.
    task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] d,
                       input logic err, input logic [31:0] exp);
        notes.push_back({wr, err, exp});
        @(posedge mclk_in);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= {idx, 2'h0};
        pwdata  <= d;
        @(posedge mclk_in);
        penable <= 1'h1;
        @(posedge mclk_in);
        while (pready !== 1'h1) @(posedge mclk_in);
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [13:0] idx, input logic [31:0] d);
        apb(1'h1, idx, d, 1'h0, 32'h0);
    endtask : wr

    task automatic rd(input logic [13:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 32'h0, 1'h0, exp);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : idle

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // Clock generator.
    initial begin
        mclk_in = 1'h0;
        forever #2 mclk_in = ~mclk_in;
    end

    // Scoreboard: each completed transfer is matched with the oldest note.
    always @(posedge mclk_in) begin
        if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
            if (notes.size() == 0) chk("note queue", 32'h1, 32'h0);
            else begin
                note = notes.pop_front();
                chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
                if (!note[33]) chk("prdata", note[31:0], prdata);
            end
        end
    end

    // Watchdog: the whole sequence needs well under 2000 cycles.
    initial begin
        #40000;
        bad_count++;
        conclude();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {alt_drive, alt_oe, ext_en, ext_val} = '0;
        pstrb = 4'hf;
        // The core model enables its peripheral line in its own mask.
        core_irq_mask = 16'h0200;
        reset_in = 1'h1;
        idle(12);
        reset_in <= 1'h0;
        // Reset values, then an unmapped word which must be refused.
        rd(IDX_FUNC_SEL, 32'hff);
        rd(IDX_DATA_LINE8, 32'h2);
        rd(IDX_DIR_LOW, 32'h0);
        rd(IDX_DIR_LINE8, 32'h0);
        rd(IDX_IEN_LOW, 32'h0);
        rd(IDX_IEN_LINE8, 32'h0);
        rd(IDX_DATA_LOW, 32'h0);
        apb(1'h0, 14'h2048, 32'h0, 1'h1, 32'h0);
        // Outputs: enabled lines driven by the port itself must not flag.
        wr(IDX_IEN_LOW, 32'hff);
        wr(IDX_IEN_LINE8, 32'h1);
        wr(IDX_IRQ_MASK, 32'h3);
        r = xorshift();
        wr(IDX_DIR_LOW, 32'hff);
        wr(IDX_DIR_LINE8, 32'h1);
        wr(IDX_DATA_LOW, {24'h0, r});
        wr(IDX_DATA_LINE8, 32'h3);
        idle(2);
        chk("pad oe", 32'h1ff, {23'h0, pad.oe});
        chk("pad out", {23'h1, r}, {23'h0, pad.out});
        rd(IDX_DATA_LOW, {24'h0, r});
        // Hand the lines back as inputs at the same level, so nothing changes.
        v = {1'h1, r};
        ext_val <= v;
        ext_en  <= 9'h1ff;
        wr(IDX_DIR_LOW, 32'h0);
        wr(IDX_DIR_LINE8, 32'h0);
        idle(6);
        rd(IDX_FLAG_LOW, 32'h0);
        rd(IDX_FLAG_LINE8, 32'h0);
        // Toggle lines one and eight.
        v = v ^ 9'h102;
        ext_val <= v;
        idle(6);
        chk("irq line", 32'h0, {31'h0, irq_n});
        chk("irq out", 32'h1, {31'h0, irq});
        chk("core request", 32'h1, {31'h0, core_irq_mask[9] && !irq_n});
        rd(IDX_IRQ_STATUS, 32'h3);
        rd(IDX_FLAG_LOW, 32'h2);
        rd(IDX_FLAG_LOW, 32'h0);
        chk("irq line held", 32'h0, {31'h0, irq_n});
        rd(IDX_FLAG_LINE8, 32'h1);
        idle(2);
        chk("irq line free", 32'h1, {31'h0, irq_n});
        wr(IDX_IRQ_STATUS, 32'h3);
        rd(IDX_IRQ_STATUS, 32'h0);
        chk("irq out clear", 32'h0, {31'h0, irq});
        // Masked: the port request still goes low, the level output stays quiet.
        wr(IDX_IRQ_MASK, 32'h0);
        v = v ^ 9'h001;
        ext_val <= v;
        idle(6);
        chk("irq line masked", 32'h0, {31'h0, irq_n});
        chk("irq out masked", 32'h0, {31'h0, irq});
        rd(IDX_FLAG_LOW, 32'h1);
        wr(IDX_IRQ_STATUS, 32'h3);
        // Random input levels: read back, and flags mark every changed line.
        nv = xorshift();
        dv = nv ^ v;
        ext_val <= nv;
        idle(6);
        rd(IDX_DATA_LOW, {24'h0, nv[7:0]});
        rd(IDX_DATA_LINE8, {30'h0, 1'h1, nv[8]});
        rd(IDX_FLAG_LOW, {24'h0, dv[7:0]});
        rd(IDX_FLAG_LINE8, {31'h0, dv[8]});
        // Alternate roles on all nine lines.
        wr(IDX_FUNC_SEL, 32'h0);
        wr(IDX_DATA_LINE8, 32'h0);
        nv = xorshift();
        ext_en    <= 9'h0;
        alt_oe    <= 9'h1ff;
        alt_drive <= nv;
        idle(3);
        chk("alt oe", 32'h1ff, {23'h0, pad.oe});
        chk("alt out", {23'h0, nv}, {23'h0, pad.out});
        nv = xorshift();
        alt_oe  <= 9'h0;
        ext_en  <= 9'h1ff;
        ext_val <= nv;
        idle(5);
        chk("alt level", {23'h0, nv}, {23'h0, alt_lv});
        rd(IDX_FLAG_LOW, 32'h0);
        rd(IDX_FLAG_LINE8, 32'h0);
        rd(IDX_FUNC_SEL, 32'h0);
        // Serial set-up as software must do it, internal serial clock.
        wr(IDX_FUNC_SEL, 32'hd8);
        rd(IDX_FUNC_SEL, 32'hd8);
        // A write without the low strobe is ignored yet answered normally.
        pstrb <= 4'he;
        wr(IDX_FUNC_SEL, 32'h0);
        pstrb <= 4'hf;
        rd(IDX_FUNC_SEL, 32'hd8);
        idle(2);
        conclude();
    end
endmodule : testbench
